/* hw/stop_release_subclock_control.sv */
// Purpose: STOP release timing, subclock switching and peripheral clock gating
// Assumes: release and reset requests come from logic on pclk
// Notes:   registers on APB, no wait states
//
// The APB interface to the registers and the address map are this design's own decisions.
`include "clkctl_cfg.svh"
`default_nettype none

module stop_release_subclock_control
    import clkctl_pkg::*;
#(
    parameter int SETTLE_BASE = `SETTLE_BASE_LOG2,
    parameter int CNT_W       = 24
) (
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic        pready_q,
    output var  logic [31:0] prdata_q,
    output var  logic        pslverr_q,
    // release and reset sources
    input  wire logic        release_irq,
    input  wire logic        watchdog_reset_signal,
    input  wire logic        low_voltage_detector,
    input  wire logic        clock_monitor,
    // clock tree controls
    output var  logic        main_osc_en_q,
    output var  logic        sysclk_sel_sub_q,
    output var  logic [2:0]  clk_div_sel_q,
    output var  logic        cpu_clk_en_q,
    output var  logic [5:0]  periph_clk_en_q,
    output var  logic        rto_hold_q,
    output var  logic        interval_timer_clk_en_q,
    output var  logic        async_port_clk_en_q,
    output var  logic [5:0]  clocked_serial_clk_en_q,
    // analog to digital converter
    input  wire logic        adc_enable,
    input  wire logic        adc_conv_done,
    output var  logic        adc_run_q,
    output var  logic        adc_result_valid_q,
    // digital to analog converter
    input  wire logic        dac_enable,
    output var  logic        dac_conv_q,
    output var  logic        dac_out_en_q
);

    localparam logic [CNT_W-1:0] ONE_C     = CNT_W'(1);
    localparam logic [7:0]       DAC_SET_C = 8'(`DAC_SETTLE_CYC);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup_ph   = psel & ~penable;
    wire wr_acc     = psel & penable & pready_q & pwrite;
    wire wr_lane0   = wr_acc & pstrb[0];
    wire wr_lane1   = wr_acc & pstrb[1];
    wire hit_pcc    = (paddr == `OFS_PROC_CLK_CTRL);
    wire hit_settle = (paddr == `OFS_SETTLE_SEL);
    wire hit_pmode  = (paddr == `OFS_POWER_MODE);
    wire hit_stat   = (paddr == `OFS_STATUS);
    wire hit_psel   = (paddr == `OFS_PERIPH_CLK_SEL);
    wire mapped     = hit_pcc | hit_settle | hit_pmode | hit_stat | hit_psel;
    wire settle_wr  = wr_lane0 & hit_settle;
    wire psel_wr_lo = wr_lane0 & hit_psel;
    wire psel_wr_hi = wr_lane1 & hit_psel;
    wire pmode_wr   = wr_lane0 & hit_pmode;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pm_state_t   state_q;
    pm_state_t   state_d;
    logic        subsel_q;
    logic        subsel_d;
    logic        mck_q;
    logic        mck_d;
    logic [2:0]  div_d;
    logic        cls_q;
    logic [2:0]  settle_sel_q;
    logic [2:0]  settle_sel_d;
    logic [1:0]  itmr_src_q;
    logic [1:0]  itmr_src_d;
    logic        async_ext_q;
    logic        async_ext_d;
    logic [5:0]  csi_ext_q;
    logic [5:0]  csi_ext_d;
    logic        start_q;
    logic        start_d;
    logic [CNT_W-1:0] len_q;
    logic [CNT_W-1:0] len_d;
    logic        stab_busy;
    logic        stab_done;
    logic [1:0]  discard_q;
    logic [1:0]  discard_d;
    logic        adc_valid_d;
    logic        dac_was_on_q;
    logic        dac_was_on_d;
    logic [7:0]  dac_wait_q;
    logic [7:0]  dac_wait_d;

    wire sys_reset_req = watchdog_reset_signal | low_voltage_detector | clock_monitor;
    wire stop_req      = pmode_wr & pwdata[`PMC_STOP_BIT];
    wire in_run        = (state_q == PM_RUN);
    wire in_stop       = (state_q == PM_STOP);
    wire stop_enter    = in_run & stop_req & ~sys_reset_req;
    wire run_enter     = (state_d == PM_RUN) & ~in_run;
    wire halted        = ~in_run;
    wire main_running  = ~mck_q & ~in_stop;

    // ----------------------------------------------------------------
    // power mode sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            PM_RESET_STAB: begin
                if (stab_done)
                    state_d = PM_RUN;
            end
            PM_RUN: begin
                if (stop_req)
                    state_d = PM_STOP;
            end
            PM_STOP: begin
                if (release_irq)
                    state_d = PM_STAB;
            end
            PM_STAB: begin
                if (stab_done)
                    state_d = PM_RUN;
            end
            default: state_d = PM_RESET_STAB;
        endcase
        if (sys_reset_req)
            state_d = PM_RESET_STAB;
    end

    // stabilisation length: selected period on interrupt release, default on reset
    wire [CNT_W-1:0] sel_len = ONE_C << (SETTLE_BASE + int'(settle_sel_q));
    wire [CNT_W-1:0] rst_len = ONE_C << (SETTLE_BASE + int'(`SETTLE_SEL_RST));
    assign start_d = (state_d == PM_RESET_STAB && sys_reset_req) | (in_stop && release_irq);
    assign len_d   = sys_reset_req ? rst_len : in_stop ? sel_len : len_q;

    stab_counter #(
        .W (CNT_W)
    ) u_stab (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start_q),
        .len     (len_q),
        .busy_q  (stab_busy),
        .done_q  (stab_done)
    );

    // ----------------------------------------------------------------
    // clock control, settle select and peripheral clock select registers
    // ----------------------------------------------------------------
    wire pcc_wr = wr_lane0 & hit_pcc;
    assign subsel_d = sys_reset_req ? 1'b0 :
                      (pcc_wr ? pwdata[`PCC_SUBSEL_BIT] : subsel_q);
    assign mck_d    = sys_reset_req ? 1'b0 :
                      (pcc_wr ? pwdata[`PCC_MCK_BIT] : mck_q);
    assign div_d    = sys_reset_req ? `DIV_RST :
                      (pcc_wr ? pwdata[`PCC_DIV_MSB:`PCC_DIV_LSB] : clk_div_sel_q);
    assign settle_sel_d = settle_wr ? pwdata[2:0] : settle_sel_q;
    assign itmr_src_d   = psel_wr_lo ? pwdata[`PSEL_ITMR_MSB:`PSEL_ITMR_LSB] : itmr_src_q;
    assign async_ext_d  = psel_wr_lo ? pwdata[`PSEL_ASYNC_BIT] : async_ext_q;
    assign csi_ext_d[4:0] = psel_wr_lo ? pwdata[7:`PSEL_CSI_LSB] : csi_ext_q[4:0];
    assign csi_ext_d[5]   = psel_wr_hi ? pwdata[`PSEL_CSI_MSB] : csi_ext_q[5];

    // ----------------------------------------------------------------
    // converters
    // ----------------------------------------------------------------
    always_comb begin
        discard_d   = discard_q;
        adc_valid_d = adc_result_valid_q;
        if (sys_reset_req) begin
            discard_d   = 2'h0;
            adc_valid_d = 1'b0;
        end else if (stop_enter) begin
            discard_d   = `ADC_DISCARD_N;
            adc_valid_d = 1'b0;
        end else if (adc_conv_done && adc_run_q) begin
            adc_valid_d = (discard_q == 2'h0);
            if (discard_q != 2'h0)
                discard_d = discard_q - 2'h1;
        end
    end

    assign dac_was_on_d = stop_enter ? dac_enable : dac_was_on_q;
    assign dac_wait_d   = (run_enter && dac_was_on_q) ? DAC_SET_C :
                          (dac_wait_q != 8'h00) ? (dac_wait_q - 8'h01) : dac_wait_q;

    // ----------------------------------------------------------------
    // apb read data
    // ----------------------------------------------------------------
    wire [31:0] rd_pcc    = {25'h0, mck_q, 1'b0, cls_q, subsel_q, clk_div_sel_q};
    wire [31:0] rd_settle = {29'h0, settle_sel_q};
    wire [31:0] rd_stat   = {26'h0, dac_out_en_q, adc_result_valid_q, main_running, stab_busy, in_stop, in_run};
    wire [31:0] rd_psel   = {23'h0, csi_ext_q, async_ext_q, itmr_src_q};
    wire [31:0] rd_mux    = hit_pcc    ? rd_pcc :
                            hit_settle ? rd_settle :
                            hit_stat   ? rd_stat :
                            hit_psel   ? rd_psel : 32'h0;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup_ph;
            prdata_q  <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
            pslverr_q <= setup_ph & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= PM_RESET_STAB;
            start_q       <= 1'b1;
            len_q         <= ONE_C << (SETTLE_BASE + int'(`SETTLE_SEL_RST));
        end else begin
            state_q       <= state_d;
            start_q       <= start_d;
            len_q         <= len_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            subsel_q      <= 1'b0;
            mck_q         <= 1'b0;
            clk_div_sel_q <= `DIV_RST;
            settle_sel_q  <= `SETTLE_SEL_RST;
        end else begin
            subsel_q      <= subsel_d;
            mck_q         <= mck_d;
            clk_div_sel_q <= div_d;
            settle_sel_q  <= settle_sel_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            itmr_src_q  <= ITMR_MAIN;
            async_ext_q <= 1'b0;
            csi_ext_q   <= 6'h00;
            discard_q   <= 2'h0;
            dac_was_on_q <= 1'b0;
            dac_wait_q  <= 8'h00;
        end else begin
            itmr_src_q  <= itmr_src_d;
            async_ext_q <= async_ext_d;
            csi_ext_q   <= csi_ext_d;
            discard_q   <= discard_d;
            dac_was_on_q <= dac_was_on_d;
            dac_wait_q  <= dac_wait_d;
        end
    end

    // ----------------------------------------------------------------
    // clock tree outputs
    // ----------------------------------------------------------------
    wire itmr_ok  = (itmr_src_q == ITMR_RING8) | (itmr_src_q == ITMR_SUB);
    wire next_run = (state_d == PM_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_osc_en_q           <= 1'b1;
            sysclk_sel_sub_q        <= 1'b0;
            cls_q                   <= 1'b0;
            cpu_clk_en_q            <= 1'b0;
        end else begin
            main_osc_en_q           <= ~mck_d & (state_d != PM_STOP);
            sysclk_sel_sub_q        <= subsel_q;
            cls_q                   <= sysclk_sel_sub_q;
            cpu_clk_en_q            <= next_run;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clk_en_q         <= 6'h00;
            rto_hold_q              <= 1'b1;
            interval_timer_clk_en_q <= 1'b0;
            async_port_clk_en_q     <= 1'b0;
            clocked_serial_clk_en_q <= 6'h00;
        end else begin
            periph_clk_en_q         <= {6{main_running & in_run}};
            rto_hold_q              <= ~main_running;
            interval_timer_clk_en_q <= main_running | itmr_ok;
            async_port_clk_en_q     <= main_running | async_ext_q;
            clocked_serial_clk_en_q <= {6{main_running}} | csi_ext_q;
        end
    end

    // ----------------------------------------------------------------
    // converter outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_run_q          <= 1'b0;
            adc_result_valid_q <= 1'b0;
        end else begin
            adc_run_q          <= adc_enable & next_run & ~mck_d;
            adc_result_valid_q <= adc_valid_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_conv_q         <= 1'b0;
            dac_out_en_q       <= 1'b0;
        end else begin
            dac_conv_q         <= dac_enable & next_run;
            dac_out_en_q       <= dac_enable & next_run & ~halted & (dac_wait_d == 8'h00);
        end
    end

endmodule

`default_nettype wire

/* hw/clkctl_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the clock controller
// Assumes: 32-bit APB, one aligned word per register
// Notes:   included by bare name
`ifndef CLKCTL_CFG_SVH
`define CLKCTL_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PROC_CLK_CTRL   12'h000
`define OFS_SETTLE_SEL      12'h004
`define OFS_POWER_MODE      12'h008
`define OFS_STATUS          12'h00C
`define OFS_PERIPH_CLK_SEL  12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCC_DIV_LSB         0
`define PCC_DIV_MSB         2
`define PCC_SUBSEL_BIT      3
`define PCC_CLS_BIT         4
`define PCC_MCK_BIT         6
`define PMC_STOP_BIT        0
`define PSEL_ITMR_LSB       0
`define PSEL_ITMR_MSB       1
`define PSEL_ASYNC_BIT      2
`define PSEL_CSI_LSB        3
`define PSEL_CSI_MSB        8

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DIV_RST             3'h0
`define SETTLE_SEL_RST      3'h3
`define SETTLE_BASE_LOG2    13
`define ADC_DISCARD_N       2'h2
`define CLK_PERIOD_NS       20
`define DAC_SETTLE_NS       2000
`define DAC_SETTLE_CYC      ((`DAC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hw/clkctl_pkg.sv */
// Purpose: types shared by the clock controller files
// Assumes: nothing
// Notes:   one-hot state codes
`default_nettype none

package clkctl_pkg;

    typedef enum logic [3:0] {
        PM_RESET_STAB = 4'b0001,
        PM_RUN        = 4'b0010,
        PM_STOP       = 4'b0100,
        PM_STAB       = 4'b1000
    } pm_state_t;

    typedef enum logic [1:0] {
        ITMR_MAIN  = 2'h0,
        ITMR_RING8 = 2'h1,
        ITMR_SUB   = 2'h2,
        ITMR_RSVD  = 2'h3
    } itmr_src_t;

endpackage

`default_nettype wire

/* hw/stab_counter.sv */
// Purpose: down counter timing an oscillation stabilisation period
// Assumes: start is a one-cycle pulse, len at least 1
// Notes:   done pulses one cycle after the last counted cycle
`default_nettype none

module stab_counter #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    // result
    output var  logic         busy_q,
    output var  logic         done_q
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         busy_d;
    logic         done_d;
    wire          last = busy_q && (cnt_q == '0);

    assign cnt_d  = start ? (len - W'(1)) : (busy_q && !last) ? (cnt_q - W'(1)) : cnt_q;
    assign busy_d = start | (busy_q & ~last);
    assign done_d = last & ~start;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

endmodule

`default_nettype wire

/* sim/clkctl_asserts.sv */
// Purpose: port-level checks of the clock controller
// Assumes: one pclk domain, zero-wait apb
// Notes:   bound to the design top below
`default_nettype none

module clkctl_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready_q,
    // sources
    input wire logic        release_irq,
    input wire logic        watchdog_reset_signal,
    input wire logic        low_voltage_detector,
    input wire logic        clock_monitor,
    // controls
    input wire logic        main_osc_en_q,
    input wire logic        sysclk_sel_sub_q,
    input wire logic        cpu_clk_en_q,
    input wire logic [5:0]  periph_clk_en_q,
    input wire logic        rto_hold_q,
    input wire logic        adc_run_q,
    input wire logic        adc_result_valid_q,
    input wire logic        dac_out_en_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic ctrl_wr = psel && penable && pwrite && pready_q && paddr == 12'h000 && pstrb[0];
    // ------
    // sequences
    // ------
    sequence in_stop;
        !cpu_clk_en_q && !main_osc_en_q;
    endsequence
    sequence rst_src;
        watchdog_reset_signal || low_voltage_detector || clock_monitor;
    endsequence
    // ------
    // checks
    // ------
    a_apb_zero_wait: assert property (psel && !penable |=> pready_q)
        else $error("pready late");
    a_ready_pulse: assert property (pready_q |=> !pready_q)
        else $error("pready held");
    a_stop_release: assert property (in_stop ##0 release_irq |=> !cpu_clk_en_q [*3] ##[1:1000] cpu_clk_en_q)
        else $error("release timing wrong");
    a_stop_gates: assert property ($fell(cpu_clk_en_q) && !main_osc_en_q |-> !dac_out_en_q && !adc_run_q)
        else $error("converters not halted");
    a_dac_settle: assert property ($rose(cpu_clk_en_q) |-> !dac_out_en_q [*8])
        else $error("dac drives too early");
    a_adc_discard: assert property ($rose(cpu_clk_en_q) |-> !adc_result_valid_q)
        else $error("stale adc result valid");
    a_gate_periph: assert property (!main_osc_en_q && !$past(main_osc_en_q) |-> periph_clk_en_q == 6'h00 && rto_hold_q)
        else $error("peripheral clock not gated");
    a_osc_stop: assert property (ctrl_wr && pwdata[6] |=> ##[0:2] !main_osc_en_q)
        else $error("main osc not stopped");
    a_sub_enter: assert property (ctrl_wr && pwdata[3] && cpu_clk_en_q |=> ##[0:3] sysclk_sel_sub_q)
        else $error("subclock not selected");
    a_reset_src: assert property (rst_src |=> ##1 !sysclk_sel_sub_q)
        else $error("reset source kept subclock");
endmodule

bind stop_release_subclock_control clkctl_asserts i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready_q(pready_q), .release_irq(release_irq),
    .watchdog_reset_signal(watchdog_reset_signal), .low_voltage_detector(low_voltage_detector),
    .clock_monitor(clock_monitor), .main_osc_en_q(main_osc_en_q), .sysclk_sel_sub_q(sysclk_sel_sub_q),
    .cpu_clk_en_q(cpu_clk_en_q), .periph_clk_en_q(periph_clk_en_q), .rto_hold_q(rto_hold_q),
    .adc_run_q(adc_run_q), .adc_result_valid_q(adc_result_valid_q), .dac_out_en_q(dac_out_en_q)
);

`default_nettype wire

/* sim/stop_release_subclock_control_tb.sv */
// Purpose: self-checking bench of the clock controller
// Assumes: SETTLE_BASE of 2 shortens every stabilisation count
// Notes:   expectations come from literal constants and the bench model variables
`include "clkctl_cfg.svh"
`default_nettype none

module stop_release_subclock_control_tb
    import clkctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SB = 2;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        release_irq = 1'b0, watchdog_reset_signal = 1'b0, low_voltage_detector = 1'b0;
    logic        clock_monitor = 1'b0, adc_enable = 1'b0, adc_conv_done = 1'b0, dac_enable = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata_q, rdat, rnd = 32'h3BADCBDC;
    logic [3:0]  pstrb = 4'hF;
    logic        pready_q, pslverr_q, rerr, main_osc_en_q, sysclk_sel_sub_q, cpu_clk_en_q, rto_hold_q;
    logic        interval_timer_clk_en_q, async_port_clk_en_q, adc_run_q, adc_result_valid_q;
    logic        dac_conv_q, dac_out_en_q;
    logic [2:0]  clk_div_sel_q, m_div;
    logic [5:0]  periph_clk_en_q, clocked_serial_clk_en_q;
    logic [8:0]  m_ps = 9'h000;
    int          num_errors = 0, cmp_count = 0, cyc, s, k;
    bit          m_adc[$];

    stop_release_subclock_control #(.SETTLE_BASE(SB)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready_q, .prdata_q,
        .pslverr_q, .release_irq, .watchdog_reset_signal, .low_voltage_detector, .clock_monitor,
        .main_osc_en_q, .sysclk_sel_sub_q, .clk_div_sel_q, .cpu_clk_en_q, .periph_clk_en_q,
        .rto_hold_q, .interval_timer_clk_en_q, .async_port_clk_en_q, .clocked_serial_clk_en_q,
        .adc_enable, .adc_conv_done, .adc_run_q, .adc_result_valid_q, .dac_enable, .dac_conv_q,
        .dac_out_en_q
    );

    always #10 pclk = ~pclk;

    // ------
    // tasks
    // ------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            tally_and_finish();
        end
        rdat = prdata_q;
        rerr = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_for(input int sel, input int lim);
        cyc = 0;
        while ((sel == 1 ? dac_out_en_q : cpu_clk_en_q) !== 1'b1) begin
            @(posedge pclk);
            cyc++;
            if (cyc > lim) begin
                num_errors++;
                tally_and_finish();
            end
        end
    endtask

    // ------
    // sequence
    // ------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wait_for(0, 200);
        chk("reset stab", 1, cyc >= (1 << (SB + 3)) && cyc <= (1 << (SB + 3)) + 8);
        apb(1'b0, `OFS_SETTLE_SEL, 0);
        chk("settle rst", 3, rdat);
        apb(1'b0, `OFS_STATUS, 0);
        chk("status run", 32'h9, rdat & 32'hF);
        apb(1'b0, 12'h020, 0);
        chk("unmapped err", 1, rerr);
        chk("unmapped data", 0, rdat);
        adc_enable <= 1'b1;
        dac_enable <= 1'b1;
        for (s = 0; s < 2; s++) begin
            apb(1'b1, `OFS_SETTLE_SEL, s);
            apb(1'b1, `OFS_POWER_MODE, 1);
            @(posedge pclk);
            chk("stop dac oe", 0, dac_out_en_q);
            chk("stop adc run", 0, adc_run_q);
            chk("stop cpu", 0, cpu_clk_en_q);
            chk("stop dac conv", 0, dac_conv_q);
            repeat (4) @(posedge pclk);
            release_irq <= 1'b1;
            @(posedge pclk);
            release_irq <= 1'b0;
            wait_for(0, 2000);
            chk("release len", 1, cyc >= (1 << (SB + s)) && cyc <= (1 << (SB + s)) + 4);
            wait_for(1, 200);
            chk("dac settle", 1, cyc >= 95 && cyc <= 105);
            chk("dac conv", 1, dac_conv_q);
            apb(1'b0, `OFS_STATUS, 0);
            chk("status after", 32'h29, rdat & 32'h3F);
            m_adc = '{1'b0, 1'b0, 1'b1};
            for (k = 0; k < 3; k++) begin
                adc_conv_done <= 1'b1;
                @(posedge pclk);
                adc_conv_done <= 1'b0;
                @(posedge pclk);
                chk("adc valid", m_adc.pop_front(), adc_result_valid_q);
            end
        end
        rnd = lfsr(rnd);
        m_div = rnd[2:0];
        apb(1'b1, `OFS_PROC_CLK_CTRL, m_div);
        apb(1'b1, `OFS_PROC_CLK_CTRL, m_div | 32'h8);
        repeat (3) @(posedge pclk);
        apb(1'b0, `OFS_PROC_CLK_CTRL, 0);
        chk("ctrl sub", m_div | 32'h18, rdat & 32'h5F);
        chk("sysclk sub", 1, sysclk_sel_sub_q);
        chk("divider", m_div, clk_div_sel_q);
        apb(1'b1, `OFS_PROC_CLK_CTRL, m_div | 32'h48);
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            m_ps = rnd[8:0];
            apb(1'b1, `OFS_PERIPH_CLK_SEL, rnd);
            @(posedge pclk);
            chk("osc stop", 0, main_osc_en_q);
            chk("periph", 0, periph_clk_en_q);
            chk("rto hold", 1, rto_hold_q);
            chk("itmr", m_ps[1:0] == ITMR_RING8 || m_ps[1:0] == ITMR_SUB, interval_timer_clk_en_q);
            chk("async", m_ps[2], async_port_clk_en_q);
            chk("serial", m_ps[8:3], clocked_serial_clk_en_q);
        end
        apb(1'b1, `OFS_PROC_CLK_CTRL, m_div | 32'h8);
        repeat (8) @(posedge pclk);
        apb(1'b1, `OFS_PROC_CLK_CTRL, m_div);
        repeat (3) @(posedge pclk);
        chk("sysclk main", 0, sysclk_sel_sub_q);
        chk("periph run", 6'h3F, periph_clk_en_q);
        for (k = 0; k < 3; k++) begin
            apb(1'b1, `OFS_PROC_CLK_CTRL, m_div | 32'h8);
            {clock_monitor, low_voltage_detector, watchdog_reset_signal} <= 3'(1 << k);
            @(posedge pclk);
            {clock_monitor, low_voltage_detector, watchdog_reset_signal} <= 3'h0;
            repeat (2) @(posedge pclk);
            chk("src sysclk", 0, sysclk_sel_sub_q);
            wait_for(0, 200);
            chk("src adc valid", 0, adc_result_valid_q);
            apb(1'b0, `OFS_PROC_CLK_CTRL, 0);
            chk("src ctrl", 0, rdat & 32'h5F);
            apb(1'b0, `OFS_PERIPH_CLK_SEL, 0);
            chk("psel kept", m_ps, rdat);
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
